// ==== bvc_defines.svh ====
// Offsets, field positions, reset values and counts of the capture block
// Assumes a 32-bit register port addressed by byte, one word per register
`ifndef BVC_DEFINES_SVH
`define BVC_DEFINES_SVH

// Register port
`define BVC_ADDR_W 4
`define BVC_DATA_W 32
`define BVC_OFS_VECTOR 4'h0
`define BVC_OFS_PCICTL 4'h4
`define BVC_OFS_STATUS 4'h8

// Vector field positions
`define BVC_VEC_W 16
`define BVC_F_PLL_HI 2
`define BVC_F_PLL_LO 0
`define BVC_F_ENDIAN 3
`define BVC_F_WIDTH_HI 6
`define BVC_F_WIDTH_LO 5
`define BVC_F_RSTMODE 7
`define BVC_F_WDT 8
`define BVC_F_PCI_HI 11
`define BVC_F_PCI_LO 9

// Control and status bits
`define BVC_F_PCI_EN 0
`define BVC_F_ST_DONE 0
`define BVC_F_ST_WARM 1
`define BVC_F_ST_RSVD 2

// Reset values
`define BVC_VECTOR_RST 16'h0000
`define BVC_PCI_EN_RST 1'b0
`define BVC_RDATA_RST 32'h0000_0000

// Warm reset drive length in mclk cycles
`define BVC_WARM_CYCLES 4096

`endif

// ==== bvc_pkg.sv ====
// Types of the boot vector capture block
// Assumes bvc_defines.svh is on the include path
`default_nettype none

package bvc_pkg;

   typedef enum logic [2:0] {
      BVC_PCI_OFF = 3'h0,
      BVC_PCI_SAT_NRDY = 3'h1,
      BVC_PCI_SAT_SUSP = 3'h2,
      BVC_PCI_HOST_EXT = 3'h3,
      BVC_PCI_HOST_FIX = 3'h4,
      BVC_PCI_HOST_RR = 3'h5,
      BVC_PCI_RSVD6 = 3'h6,
      BVC_PCI_RSVD7 = 3'h7
   } bvc_pci_mode_t;

   typedef struct packed {
      logic [2:0] pll_mult;
      logic big_endian;
      logic [1:0] dev_width;
      logic reset_mode;
      logic wdt_disable;
      bvc_pci_mode_t pci_mode;
   } bvc_cfg_t;

   typedef enum logic [2:0] {
      BVC_ST_CAPTURE = 3'b001,
      BVC_ST_WARM = 3'b010,
      BVC_ST_RUN = 3'b100
   } bvc_state_t;

endpackage : bvc_pkg

`default_nettype wire

// ==== bvc_capture.sv ====
// Boot vector capture, decode and register port
// Assumes straps on the data pins are stable up to the first enabled mclk edge after reset_n rises
//
// Operation
// - Sample the vector at cold reset, settings govern once reset ends.
// - Bits 2:0 pick the CPU clock multiplier; only code 0 is defined.
// - Bit 3 selects byte order, 0 little, 1 big endian.
// - Bit 4 has no function and is kept readable in the vector field.
// - Bits 6:5 give boot device width 8, 16, 32; code 3 reserved.
// - Bit 7 picks warm reset length; 0 drives it 4096 cycles or more. The code drives WARM_CYCLES for either value and flags 1 as reserved.
// - Bit 8 set disables the watchdog after cold reset.
// - Bits 11:9 select PCI mode; codes 6 and 7 reserved.
// - PCI enable resets to one for satellite modes, else zero.
// - Bits 15:12 have no function and are kept readable.
//
// Local design decisions: the register addresses and the strobed register port.
`timescale 1ns/100ps
`default_nettype none
`include "bvc_defines.svh"

module bvc_capture
   import bvc_pkg::*;
#(
   parameter int WARM_CYCLES = `BVC_WARM_CYCLES
) (
   // Clock, cold reset, enable
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic clk_en,
   // Strap pins
   input wire logic [`BVC_VEC_W-1:0] memory_data_pins,
   // Warm reset pin
   input wire logic warm_reset_pin_in_n,
   output logic warm_reset_pin_out_n,
   output logic warm_reset_pin_oe,
   // Register port
   input wire logic [`BVC_ADDR_W-1:0] reg_addr,
   input wire logic [`BVC_DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [`BVC_DATA_W-1:0] reg_rdata,
   // Decoded settings
   output bvc_cfg_t cfg_out,
   output logic cfg_valid,
   output logic cfg_reserved,
   output logic pci_enable
);

   localparam int CNT_W = $clog2(WARM_CYCLES + 1);

   generate
      if (WARM_CYCLES < 1) begin : g_bad_cycles
         $error("WARM_CYCLES must be at least one");
      end
      if (`BVC_DATA_W < `BVC_VEC_W) begin : g_bad_width
         $error("Register word narrower than the vector");
      end
   endgenerate

   // Enable initial value from the PCI mode
   function automatic logic pci_en_init(input bvc_pci_mode_t m);
      logic r;
      r = `BVC_PCI_EN_RST;
      if (m == BVC_PCI_SAT_NRDY || m == BVC_PCI_SAT_SUSP) begin
         r = 1'b1;
      end
      return r;
   endfunction : pci_en_init

   // Vector split into fields
   function automatic bvc_cfg_t decode(input logic [`BVC_VEC_W-1:0] v);
      bvc_cfg_t c;
      c.pll_mult = v[`BVC_F_PLL_HI:`BVC_F_PLL_LO];
      c.big_endian = v[`BVC_F_ENDIAN];
      c.dev_width = v[`BVC_F_WIDTH_HI:`BVC_F_WIDTH_LO];
      c.reset_mode = v[`BVC_F_RSTMODE];
      c.wdt_disable = v[`BVC_F_WDT];
      c.pci_mode = bvc_pci_mode_t'(v[`BVC_F_PCI_HI:`BVC_F_PCI_LO]);
      return c;
   endfunction : decode

   bvc_state_t state_reg;
   logic [`BVC_VEC_W-1:0] vec_reg;
   bvc_cfg_t cfg_reg;
   logic rsvd_reg;
   logic pci_en_reg;
   logic [CNT_W-1:0] warm_cnt_reg;
   logic [`BVC_DATA_W-1:0] rdata_reg;
   bvc_cfg_t cfg_next;
   logic rsvd_next;
   logic capture;
   logic captured;
   logic warm_in_low;

   assign capture = clk_en && (state_reg == BVC_ST_CAPTURE);
   assign captured = (state_reg != BVC_ST_CAPTURE);
   assign warm_in_low = !warm_reset_pin_in_n && !warm_reset_pin_oe;
   assign cfg_next = decode(memory_data_pins);

   // Reserved codes seen on the straps
   always_comb begin
      rsvd_next = 1'b0;
      if (cfg_next.pll_mult != 3'h0) begin
         rsvd_next = 1'b1;
      end
      if (cfg_next.dev_width == 2'h3) begin
         rsvd_next = 1'b1;
      end
      if (cfg_next.reset_mode) begin
         rsvd_next = 1'b1;
      end
      if (cfg_next.pci_mode == BVC_PCI_RSVD6 ||
          cfg_next.pci_mode == BVC_PCI_RSVD7) begin
         rsvd_next = 1'b1;
      end
   end

   // Sequencer: capture, warm reset drive, run
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         state_reg <= BVC_ST_CAPTURE;
      end else if (clk_en) begin
         case (state_reg)
            BVC_ST_CAPTURE: begin
               state_reg <= BVC_ST_WARM;
            end
            BVC_ST_WARM: begin
               if (warm_cnt_reg == CNT_W'(WARM_CYCLES - 1)) begin
                  state_reg <= BVC_ST_RUN;
               end
            end
            BVC_ST_RUN: begin
               state_reg <= BVC_ST_RUN;
            end
            default: begin
               state_reg <= BVC_ST_CAPTURE;
            end
         endcase
      end
   end

   // Vector latch at first enabled edge after release, kept until cold reset
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         vec_reg <= `BVC_VECTOR_RST;
         cfg_reg <= '0;
         rsvd_reg <= 1'b0;
      end else if (capture) begin
         vec_reg <= memory_data_pins;
         cfg_reg <= cfg_next;
         rsvd_reg <= rsvd_next;
      end
   end

   // Warm reset drive length
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         warm_cnt_reg <= '0;
      end else if (clk_en && state_reg == BVC_ST_WARM) begin
         warm_cnt_reg <= warm_cnt_reg + CNT_W'(1);
      end
   end

   // PCI enable: strap default, software writable, reload on warm reset
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         pci_en_reg <= `BVC_PCI_EN_RST;
      end else if (clk_en) begin
         if (capture) begin
            pci_en_reg <= pci_en_init(cfg_next.pci_mode);
         end else if (warm_in_low) begin
            pci_en_reg <= pci_en_init(cfg_reg.pci_mode);
         end else if (reg_wr && reg_addr == `BVC_OFS_PCICTL) begin
            pci_en_reg <= reg_wdata[`BVC_F_PCI_EN];
         end
      end
   end

   // Read data, one cycle after the strobe
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         rdata_reg <= `BVC_RDATA_RST;
      end else if (clk_en) begin
         rdata_reg <= `BVC_RDATA_RST;
         if (reg_rd) begin
            case (reg_addr)
               `BVC_OFS_VECTOR: begin
                  rdata_reg[`BVC_VEC_W-1:0] <= vec_reg;
               end
               `BVC_OFS_PCICTL: begin
                  rdata_reg[`BVC_F_PCI_EN] <= pci_en_reg;
               end
               `BVC_OFS_STATUS: begin
                  rdata_reg[`BVC_F_ST_DONE] <= captured;
                  rdata_reg[`BVC_F_ST_WARM] <= warm_reset_pin_oe;
                  rdata_reg[`BVC_F_ST_RSVD] <= rsvd_reg;
               end
               default: begin
                  rdata_reg <= `BVC_RDATA_RST;
               end
            endcase
         end
      end
   end

   assign reg_rdata = rdata_reg;
   assign cfg_out = cfg_reg;
   assign cfg_valid = captured;
   assign cfg_reserved = rsvd_reg;
   assign pci_enable = pci_en_reg;
   assign warm_reset_pin_oe = (state_reg == BVC_ST_WARM);
   assign warm_reset_pin_out_n = 1'b0;

   // Checks
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!reset_n);

   // Enabled cycles of warm drive
   int unsigned oe_len;
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         oe_len <= 0;
      end else if (warm_reset_pin_oe) begin
         if (clk_en) begin
            oe_len <= oe_len + 1;
         end
      end else begin
         oe_len <= 0;
      end
   end

   chk_vec_capture: assert property (
      capture |=> vec_reg == $past(memory_data_pins) && cfg_valid)
      else $error("Vector not latched at reset release");

   chk_vec_hold: assert property (
      captured && $past(captured) |-> $stable(vec_reg))
      else $error("Latched vector changed after capture");

   chk_pll_field: assert property (
      capture |=> cfg_out.pll_mult == $past(memory_data_pins[2:0]))
      else $error("Multiplier field differs from strap");

   chk_endian_bit: assert property (
      cfg_valid |-> cfg_out.big_endian == vec_reg[3])
      else $error("Byte order differs from latched bit");

   chk_vector_read: assert property (
      reg_rd && clk_en && reg_addr == `BVC_OFS_VECTOR
      |=> reg_rdata == {16'h0000, $past(vec_reg)})
      else $error("Vector read does not show latched bits");

   chk_width_field: assert property (
      cfg_valid |-> cfg_out.dev_width == vec_reg[6:5])
      else $error("Device width differs from latched field");

   chk_warm_length: assert property (
      $fell(warm_reset_pin_oe) |-> oe_len >= WARM_CYCLES)
      else $error("Warm reset released too early");

   chk_warm_exact: assert property (
      $fell(warm_reset_pin_oe) |-> oe_len == WARM_CYCLES)
      else $error("Warm reset drive length not the set count");

   chk_warm_start: assert property (
      capture |=> warm_reset_pin_oe && !warm_reset_pin_out_n)
      else $error("Warm reset not driven after capture");

   chk_wdt_bit: assert property (
      cfg_valid |-> cfg_out.wdt_disable == vec_reg[8])
      else $error("Watchdog bit differs from latched bit");

   chk_pci_mode: assert property (
      cfg_valid |-> cfg_out.pci_mode == vec_reg[11:9])
      else $error("PCI mode differs from latched field");

   chk_pci_en_init: assert property (
      $rose(cfg_valid) |-> pci_enable ==
      (vec_reg[11:9] == 3'h1 || vec_reg[11:9] == 3'h2))
      else $error("PCI enable initial value wrong");

   chk_rsvd_flag: assert property (
      capture |=> cfg_reserved == ($past(memory_data_pins[2:0]) != 3'h0 ||
      $past(memory_data_pins[6:5]) == 2'h3 || $past(memory_data_pins[7]) ||
      $past(memory_data_pins[11:9]) > 3'h5))
      else $error("Reserved code flag wrong");

   chk_reset_field: assert property (
      capture |=> cfg_out.reset_mode == $past(memory_data_pins[7]))
      else $error("Reset mode field differs from strap");

   chk_wdt_capture: assert property (
      capture |=> cfg_out.wdt_disable == $past(memory_data_pins[8]))
      else $error("Watchdog field differs from strap");

   chk_cfg_stays: assert property (
      cfg_valid |=> cfg_valid)
      else $error("Settings dropped before cold reset");

   chk_warm_once: assert property (
      captured && !warm_reset_pin_oe |=> !warm_reset_pin_oe)
      else $error("Warm reset driven again after release");

   chk_pci_reload: assert property (
      clk_en && !capture && !warm_reset_pin_in_n && !warm_reset_pin_oe
      |=> pci_enable == (cfg_out.pci_mode == BVC_PCI_SAT_NRDY ||
      cfg_out.pci_mode == BVC_PCI_SAT_SUSP))
      else $error("PCI enable not reloaded on warm reset");

   chk_pci_write: assert property (
      clk_en && !capture && reg_wr && reg_addr == `BVC_OFS_PCICTL &&
      (warm_reset_pin_in_n || warm_reset_pin_oe)
      |=> pci_enable == $past(reg_wdata[`BVC_F_PCI_EN]))
      else $error("PCI enable write lost");

   chk_rdata_idle: assert property (
      clk_en && !reg_rd |=> reg_rdata == `BVC_RDATA_RST)
      else $error("Read data not cleared after read cycle");

   chk_status_read: assert property (
      reg_rd && clk_en && reg_addr == `BVC_OFS_STATUS
      |=> reg_rdata == {29'h0000_0000, $past(rsvd_reg),
      $past(warm_reset_pin_oe), $past(captured)})
      else $error("Status read wrong");

   chk_clk_freeze: assert property (
      !clk_en |=> $stable(state_reg) && $stable(vec_reg) &&
      $stable(cfg_reg) && $stable(pci_en_reg) && $stable(warm_cnt_reg) &&
      $stable(rdata_reg))
      else $error("State moved while clock enable low");

   // Scenario covers
   cov_big_endian: cover property (capture && memory_data_pins[3]);
   cov_satellite: cover property ($rose(cfg_valid) && pci_enable);
   cov_warm_done: cover property ($fell(warm_reset_pin_oe));
   cov_en_write: cover property (
      clk_en && reg_wr && reg_addr == `BVC_OFS_PCICTL ##1 pci_enable);
   cov_warm_reload: cover property (
      clk_en && captured && !warm_reset_pin_in_n && !warm_reset_pin_oe);

endmodule : bvc_capture

`default_nettype wire

// ==== bvc_strap_model.sv ====
// Board side model: strap drivers on the data pins and the warm reset pin
// Assumes the bench sets the strap value before cold reset is released
`timescale 1ns/100ps
`default_nettype none

module bvc_strap_model (
   // Clock and cold reset
   input wire logic mclk,
   input wire logic reset_n,
   // Board controls
   input wire logic [15:0] strap_value,
   input wire logic ext_warm_n,
   // Device warm reset driver
   input wire logic warm_oe,
   input wire logic warm_out_n,
   // Pins
   output logic [15:0] memory_data_pins,
   output logic warm_pin_level
);
   logic held_reg;

   // Straps held through the capture edge, then released
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         held_reg <= 1'b1;
      end else begin
         held_reg <= 1'b0;
      end
   end

   // Any level on the upper bits; released lines show the inverse
   assign memory_data_pins = held_reg ? strap_value : ~strap_value;
   // Pulled up unless someone drives it low
   assign warm_pin_level = warm_oe ? warm_out_n : ext_warm_n;
endmodule : bvc_strap_model

`default_nettype wire

// ==== boot_config_vector_capture_test.sv ====
// Testbench of the boot vector capture block
// Assumes the board model above and a small warm reset count
`timescale 1ns/100ps
`default_nettype none
`include "bvc_defines.svh"

module boot_config_vector_capture_test;
   import bvc_pkg::*;
   localparam int WARM = 8;
   logic mclk = 1'b0, reset_n = 1'b0, ext_warm_n = 1'b1;
   logic reg_wr = 1'b0, reg_rd = 1'b0, clk_en = 1'b1;
   logic [3:0] reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h0000_0000, rd_val;
   logic [15:0] strap = 16'h0000, pins;
   logic oe, out_n, pin_lvl, cfg_valid, cfg_reserved, pci_enable;
   logic [31:0] reg_rdata;
   bvc_cfg_t cfg_out;
   int fail_count = 0, checked = 0;
   logic [15:0] vecs [8] = '{16'h0000, 16'h0208, 16'h0430, 16'h0740,
      16'h8880, 16'hAB60, 16'h5C01, 16'hFFFF};

   always #5 mclk = ~mclk;

   bvc_strap_model u_board (.mclk(mclk), .reset_n(reset_n),
      .strap_value(strap), .ext_warm_n(ext_warm_n), .warm_oe(oe),
      .warm_out_n(out_n), .memory_data_pins(pins),
      .warm_pin_level(pin_lvl));

   bvc_capture #(.WARM_CYCLES(WARM)) u_dut (.mclk(mclk),
      .reset_n(reset_n), .clk_en(clk_en), .memory_data_pins(pins),
      .warm_reset_pin_in_n(pin_lvl), .warm_reset_pin_out_n(out_n),
      .warm_reset_pin_oe(oe), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .cfg_out(cfg_out), .cfg_valid(cfg_valid),
      .cfg_reserved(cfg_reserved), .pci_enable(pci_enable));

   task chk(input string what, input logic [31:0] exp, got);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge mclk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask : wr

   task rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge mclk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask : rd

   // Cold boot with one strap value; checks decode and warm drive
   task boot(input logic [15:0] v);
      bvc_cfg_t e;
      int n;
      e = bvc_cfg_t'({v[2:0], v[3], v[6:5], v[7], v[8], v[11:9]});
      strap = v;
      @(posedge mclk);
      reset_n <= 1'b0;
      repeat (6) @(posedge mclk);
      reset_n <= 1'b1;
      @(posedge mclk);
      #1 chk("valid", 32'(1), 32'(cfg_valid));
      n = 0;
      while (oe === 1'b1 && n < 100) begin
         n++;
         @(posedge mclk);
         #1;
      end
      chk("warm cycles", WARM, n);
      chk("cfg", 32'(e), 32'(cfg_out));
      chk("rsvd", 32'(v[2:0] != 0 || v[6:5] == 3 || v[7] || v[11:9] > 5),
         32'(cfg_reserved));
      chk("pci en", 32'(v[11:9] == 1 || v[11:9] == 2),
         32'(pci_enable));
      rd(`BVC_OFS_VECTOR, rd_val);
      chk("vector", {16'h0000, v}, rd_val);
   endtask : boot

   // Software write, external warm reset, read-only and unmapped places
   task warm_and_map;
      logic d;
      d = pci_enable;
      wr(`BVC_OFS_PCICTL, {31'h0000_0000, ~d});
      rd(`BVC_OFS_PCICTL, rd_val);
      chk("pcictl wr", {31'h0000_0000, ~d}, rd_val);
      wr(`BVC_OFS_VECTOR, 32'h0000_1234);
      rd(4'hC, rd_val);
      chk("unmapped", 32'h0000_0000, rd_val);
      rd(`BVC_OFS_STATUS, rd_val);
      chk("status", 32'h0000_0005, rd_val);
      @(posedge mclk);
      ext_warm_n <= 1'b0;
      repeat (2) @(posedge mclk);
      ext_warm_n <= 1'b1;
      repeat (2) @(posedge mclk);
      #1 chk("pci reload", 32'(d), 32'(pci_enable));
      rd(`BVC_OFS_VECTOR, rd_val);
      chk("vec kept", {16'h0000, strap}, rd_val);
   endtask : warm_and_map

   // Cold boot with the clock enable low for three cycles of warm drive
   task freeze_warm(input logic [15:0] v);
      int n;
      strap = v;
      @(posedge mclk);
      reset_n <= 1'b0;
      repeat (6) @(posedge mclk);
      reset_n <= 1'b1;
      @(posedge mclk);
      clk_en <= 1'b0;
      repeat (3) @(posedge mclk);
      clk_en <= 1'b1;
      #1 n = 3;
      while (oe === 1'b1 && n < 100) begin
         n++;
         @(posedge mclk);
         #1;
      end
      chk("frozen warm", WARM + 3, n);
      chk("frozen pci", 32'(1), 32'(pci_enable));
      rd(`BVC_OFS_VECTOR, rd_val);
      chk("frozen vec", {16'h0000, v}, rd_val);
   endtask : freeze_warm

   task end_sim;
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : end_sim

   initial begin
      foreach (vecs[i]) begin
         boot(vecs[i]);
      end
      warm_and_map();
      freeze_warm(16'h0410);
      end_sim();
   end

   initial begin
      #100000;
      fail_count++;
      end_sim();
   end
endmodule : boot_config_vector_capture_test

`default_nettype wire
